// ===== design/p1cfg_top.sv
// indirect configuration register for the eight pins of port 1
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
`include "p1cfg_defs.svh"
module p1cfg_top
    import p1cfg_pkg::*;
(
    input  wire logic         clk_sys,       // processor clock, 40 MHz
    input  wire logic         rst_n,         // async reset, low
    input  wire p1cfg_byte_t  busAddr,       // register address
    input  wire p1cfg_byte_t  busWdata,      // write data
    input  wire logic         busWr,         // write strobe
    input  wire logic         busRd,         // read strobe
    output p1cfg_byte_t       busRdata_r,    // read data, next cycle
    output logic [7:0]        pinHighDrv,    // high drive per pin
    output logic [7:0]        pinPullUp,     // pull-up per pin
    output logic [7:0]        pinPullDn,     // pull-down per pin
    output logic [7:0]        pinInBufEn,    // input buffer per pin
    output logic [7:0]        pinOutIllegal, // illegal output mode
    output p1cfg_idx_t        readIdx_r,     // saved read index
    output logic              readDirIn_r    // saved read direction
);

    ////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic addrHit(input p1cfg_byte_t a);
        return a == `P1CFG_ADDR;
    endfunction

    logic          hitWr;
    logic          hitRd;
    logic          outWr;
    logic          inWr;
    logic          ptrWr;
    p1cfg_idx_t    wrIdx;
    logic          wrDirIn;
    p1cfg_omode_t  wrMode;

    assign hitWr = busWr && addrHit(busAddr);
    assign hitRd = busRd && addrHit(busAddr);

    p1cfg_decode u_decode
    (
        .hitWr   (hitWr),
        .wrData  (busWdata),
        .outWr   (outWr),
        .inWr    (inWr),
        .ptrWr   (ptrWr),
        .wrIdx   (wrIdx),
        .wrDirIn (wrDirIn),
        .wrMode  (wrMode)
    );

    ////////////////////////////////////////////////////////////////////
    // per-pin function storage

    p1cfg_omode_t  outMode [`P1CFG_NPINS];
    logic [1:0]    inMode  [`P1CFG_NPINS];
    logic [23:0]   allOut;
    logic [15:0]   allIn;

    genvar gi;
    generate
        for (gi = 0; gi < `P1CFG_NPINS; gi++)
        begin : g_pin
            logic selPin;

            assign selPin = (wrIdx == p1cfg_idx_t'(gi));

            p1cfg_pin_store u_pin
            (
                .clk_sys      (clk_sys),
                .rst_n        (rst_n),
                .outWr        (outWr && selPin),
                .inWr         (inWr && selPin),
                .modeIn       (wrMode),
                .outMode_r    (outMode[gi]),
                .inMode_r     (inMode[gi]),
                .highDrv_r    (pinHighDrv[gi]),
                .pullUp_r     (pinPullUp[gi]),
                .pullDn_r     (pinPullDn[gi]),
                .inBufEn_r    (pinInBufEn[gi]),
                .outIllegal_r (pinOutIllegal[gi])
            );

            assign allOut[gi*3 +: 3] = outMode[gi];
            assign allIn[gi*2 +: 2]  = inMode[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // read pointer

    p1cfg_idx_t  readIdx_nxt;
    logic        readDirIn_nxt;

    always_comb
    begin
        readIdx_nxt   = readIdx_r;
        readDirIn_nxt = readDirIn_r;
        if (ptrWr)
        begin
            readIdx_nxt   = wrIdx;
            readDirIn_nxt = wrDirIn;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            readIdx_r   <= `P1CFG_IDX_RST;
            readDirIn_r <= `P1CFG_DIR_OUT;
        end
        else
        begin
            readIdx_r   <= readIdx_nxt;
            readDirIn_r <= readDirIn_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data

    p1cfg_omode_t  selMode;
    p1cfg_byte_t   busRdata_nxt;

    always_comb
    begin
        if (readDirIn_r == `P1CFG_DIR_IN)
            selMode = {1'b0, inMode[readIdx_r]};
        else
            selMode = outMode[readIdx_r];
        busRdata_nxt = `P1CFG_RESET;
        if (hitRd)
            busRdata_nxt = {selMode, `P1CFG_LOW_ZERO};
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            busRdata_r <= `P1CFG_RESET;
        else
            busRdata_r <= busRdata_nxt;
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    out_write_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        busWr && busAddr == `P1CFG_ADDR
        && !busWdata[`P1CFG_PTR_BIT] && !busWdata[`P1CFG_DIR_BIT]
        |=> outMode[$past(busWdata[2:0])] == $past(busWdata[7:5]))
        else $error("output mode write not applied to addressed pin");

    in_write_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        busWr && busAddr == `P1CFG_ADDR
        && !busWdata[`P1CFG_PTR_BIT] && busWdata[`P1CFG_DIR_BIT]
        |=> inMode[$past(busWdata[2:0])] == $past(busWdata[6:5]))
        else $error("input mode write not applied to addressed pin");

    dir_out_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        outWr |=> $stable(allIn))
        else $error("output write changed an input mode");

    dir_in_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        inWr |=> $stable(allOut))
        else $error("input write changed an output mode");

    ptr_keep_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        busWr && busAddr == `P1CFG_ADDR && busWdata[`P1CFG_PTR_BIT]
        |=> $stable(allOut) && $stable(allIn))
        else $error("pointer load changed a pin function");

    ptr_load_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        busWr && busAddr == `P1CFG_ADDR && busWdata[`P1CFG_PTR_BIT]
        |=> readIdx_r == $past(busWdata[2:0])
        && readDirIn_r == $past(busWdata[`P1CFG_DIR_BIT]))
        else $error("pointer load did not save index and direction");

    ptr_ignore_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ptrWr |-> !outWr && !inWr)
        else $error("pointer load also issued a mode update");

    read_data_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        busRd && busAddr == `P1CFG_ADDR
        |=> busRdata_r[7:5] == ($past(readDirIn_r)
            ? {1'b0, $past(inMode[readIdx_r])}
            : $past(outMode[readIdx_r])))
        else $error("read data is not the selected pin function");

    low_zero_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        busRdata_r[4:0] == `P1CFG_LOW_ZERO)
        else $error("read data low bits not zero");

    read_idle_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !(busRd && busAddr == `P1CFG_ADDR) |=> busRdata_r == `P1CFG_RESET)
        else $error("read data present without a read");

    out_only_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        outWr |=> (($past(allOut) ^ allOut)
            & ~(24'h000007 << (3 * $past(wrIdx)))) == 24'h000000)
        else $error("output write changed another pin");

    in_only_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        inWr |=> (($past(allIn) ^ allIn)
            & ~(16'h0003 << (2 * $past(wrIdx)))) == 16'h0000)
        else $error("input write changed another pin");

    ptr_hold_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !ptrWr |=> $stable(readIdx_r) && $stable(readDirIn_r))
        else $error("read pointer moved without a pointer load");

    ptr_pads_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ptrWr |=> $stable(pinHighDrv) && $stable(pinPullUp)
        && $stable(pinPullDn) && $stable(pinInBufEn)
        && $stable(pinOutIllegal))
        else $error("pointer load changed a pad control");

    other_addr_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        busWr && !addrHit(busAddr)
        |=> $stable(allOut) && $stable(allIn)
        && $stable(readIdx_r) && $stable(readDirIn_r))
        else $error("write to another address changed state");

    modes_hold_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !outWr && !inWr |=> $stable(allOut) && $stable(allIn))
        else $error("pin function changed without a mode write");

    in_read_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        hitRd && readDirIn_r == `P1CFG_DIR_IN
        |=> busRdata_r[`P1CFG_MODE_HI] == 1'b0)
        else $error("input mode read with top bit set");

    out_drive_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        outWr |=> pinHighDrv[$past(wrIdx)]
        == ($past(wrMode) == `P1CFG_OUT_HIGH))
        else $error("high drive not set by output write");

    buf_off_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        inWr && wrMode[1:0] == P1CFG_IM_OFF
        |=> !pinInBufEn[$past(wrIdx)])
        else $error("input buffer still on after off mode");

    pull_excl_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (pinPullUp & pinPullDn) == 8'h00)
        else $error("pull-up and pull-down on together");

    drive_excl_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (pinHighDrv & pinOutIllegal) == 8'h00)
        else $error("high drive on an illegal output mode");

    pull_buf_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ((pinPullUp | pinPullDn) & ~pinInBufEn) == 8'h00)
        else $error("pull resistor on with input buffer off");

    other_read_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        busRd && !addrHit(busAddr) |=> busRdata_r == `P1CFG_RESET)
        else $error("read of another address returned data");

endmodule // p1cfg_top

// ===== shared/p1cfg_defs.svh
// constants for the port 1 pin configuration access block
// What this block does
// - Plain write applies mode field to the pin named by its index.
// - Output mode 000 is normal drive, 011 high drive, rest illegal.
// - Input mode uses low two bits: none, pull-down, pull-up, off.
// - Read returns held mode of saved pin in saved direction.
// - Direction bit 4: zero means output side, one means input side.
// - Pointer-load write only saves index and direction, no pin change.
// - Pointer-load write ignores the mode field completely.
// - Plain write updates addressed pin mode in the selected direction.
// - Pointer-load write keeps the index; later reads report that pin.
// - Index 000 to 111 selects port 1 pins 0 to 7 in order.
`ifndef P1CFG_DEFS_SVH
`define P1CFG_DEFS_SVH

`define P1CFG_ADDR      8'h9f
`define P1CFG_RESET     8'h00
`define P1CFG_MODE_HI   7
`define P1CFG_MODE_LO   5
`define P1CFG_IMODE_HI  6
`define P1CFG_DIR_BIT   4
`define P1CFG_PTR_BIT   3
`define P1CFG_IDX_HI    2
`define P1CFG_IDX_LO    0
`define P1CFG_NPINS     8
`define P1CFG_DIR_OUT   1'b0
`define P1CFG_DIR_IN    1'b1
`define P1CFG_OUT_NORM  3'h0
`define P1CFG_OUT_HIGH  3'h3
`define P1CFG_OMODE_RST 3'h0
`define P1CFG_IMODE_RST 2'h0
`define P1CFG_IDX_RST   3'h0
`define P1CFG_LOW_ZERO  5'h00
`define P1CFG_PAD_BIT   1'b0
`define P1CFG_INBUF_RST 1'b1

`endif

// ===== shared/p1cfg_pkg.sv
// types shared by the port 1 pin configuration access block
package p1cfg_pkg;

    typedef logic [2:0] p1cfg_idx_t;
    typedef logic [2:0] p1cfg_omode_t;
    typedef logic [7:0] p1cfg_byte_t;

    typedef enum logic [1:0] {
        P1CFG_IM_NOPULL = 2'b00,
        P1CFG_IM_PULLDN = 2'b01,
        P1CFG_IM_PULLUP = 2'b10,
        P1CFG_IM_OFF    = 2'b11
    } p1cfg_imode_e;

endpackage

// ===== design/p1cfg_decode.sv
// splits a register write into mode update or pointer load
`timescale 1ns/10ps
`include "p1cfg_defs.svh"
module p1cfg_decode
    import p1cfg_pkg::*;
(
    input  wire logic         hitWr,    // write strobe at our address
    input  wire p1cfg_byte_t  wrData,   // written byte
    output logic              outWr,    // update output mode
    output logic              inWr,     // update input mode
    output logic              ptrWr,    // load read pointer
    output p1cfg_idx_t        wrIdx,    // addressed pin
    output logic              wrDirIn,  // direction bit
    output p1cfg_omode_t      wrMode    // mode field
);

    function automatic logic isPtrLoad(input p1cfg_byte_t d);
        return d[`P1CFG_PTR_BIT];
    endfunction

    always_comb
    begin
        wrIdx   = wrData[`P1CFG_IDX_HI:`P1CFG_IDX_LO];
        wrDirIn = wrData[`P1CFG_DIR_BIT];
        wrMode  = wrData[`P1CFG_MODE_HI:`P1CFG_MODE_LO];
        ptrWr   = hitWr && isPtrLoad(wrData);
        outWr   = hitWr && !isPtrLoad(wrData)
                  && (wrDirIn == `P1CFG_DIR_OUT);
        inWr    = hitWr && !isPtrLoad(wrData)
                  && (wrDirIn == `P1CFG_DIR_IN);
    end

endmodule // p1cfg_decode

// ===== design/p1cfg_pin_store.sv
// held input and output function of one pin with pad controls
`timescale 1ns/10ps
`include "p1cfg_defs.svh"
module p1cfg_pin_store
    import p1cfg_pkg::*;
(
    input  wire logic          clk_sys,     // processor clock
    input  wire logic          rst_n,       // async reset, low
    input  wire logic          outWr,       // write output mode
    input  wire logic          inWr,        // write input mode
    input  wire p1cfg_omode_t  modeIn,      // new mode value
    output p1cfg_omode_t       outMode_r,   // held output mode
    output logic [1:0]         inMode_r,    // held input mode
    output logic               highDrv_r,   // high drive strength
    output logic               pullUp_r,    // pull-up on
    output logic               pullDn_r,    // pull-down on
    output logic               inBufEn_r,   // input buffer on
    output logic               outIllegal_r // illegal output mode
);

    p1cfg_omode_t  outMode_nxt;
    logic [1:0]    inMode_nxt;
    logic          highDrv_nxt;
    logic          pullUp_nxt;
    logic          pullDn_nxt;
    logic          inBufEn_nxt;
    logic          outIllegal_nxt;

    always_comb
    begin
        outMode_nxt    = outWr ? modeIn : outMode_r;
        // only low two bits for input
        inMode_nxt     = inWr ? modeIn[1:0] : inMode_r;
        highDrv_nxt    = (outMode_nxt == `P1CFG_OUT_HIGH);
        outIllegal_nxt = (outMode_nxt != `P1CFG_OUT_HIGH)
                         && (outMode_nxt != `P1CFG_OUT_NORM);
        pullUp_nxt     = (inMode_nxt == P1CFG_IM_PULLUP);
        pullDn_nxt     = (inMode_nxt == P1CFG_IM_PULLDN);
        inBufEn_nxt    = (inMode_nxt != P1CFG_IM_OFF);
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            outMode_r    <= `P1CFG_OMODE_RST;
            inMode_r     <= `P1CFG_IMODE_RST;
            highDrv_r    <= `P1CFG_PAD_BIT;
            pullUp_r     <= `P1CFG_PAD_BIT;
            pullDn_r     <= `P1CFG_PAD_BIT;
            inBufEn_r    <= `P1CFG_INBUF_RST;
            outIllegal_r <= `P1CFG_PAD_BIT;
        end
        else
        begin
            outMode_r    <= outMode_nxt;
            inMode_r     <= inMode_nxt;
            highDrv_r    <= highDrv_nxt;
            outIllegal_r <= outIllegal_nxt;
            pullUp_r     <= pullUp_nxt;
            pullDn_r     <= pullDn_nxt;
            inBufEn_r    <= inBufEn_nxt;
        end
    end

    high_drive_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        highDrv_r == (outMode_r == `P1CFG_OUT_HIGH)
        && outIllegal_r == (outMode_r != `P1CFG_OUT_HIGH
                            && outMode_r != `P1CFG_OUT_NORM))
        else $error("drive strength does not follow output mode");

    input_pull_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        inWr |=> inBufEn_r == ($past(modeIn[1:0]) != P1CFG_IM_OFF)
        && pullUp_r == ($past(modeIn[1:0]) == P1CFG_IM_PULLUP)
        && pullDn_r == ($past(modeIn[1:0]) == P1CFG_IM_PULLDN))
        else $error("pull or buffer control wrong after input write");

endmodule // p1cfg_pin_store

// ===== tb/p1cfg_top_tb_top.sv
// self-checking bench for the port 1 pin configuration register
`timescale 1ns/10ps
`include "p1cfg_defs.svh"
module p1cfg_top_tb_top
    import p1cfg_pkg::*;
();

    logic         clkSys;
    logic         rstN;
    p1cfg_byte_t  busAddr;
    p1cfg_byte_t  busWdata;
    logic         busWr;
    logic         busRd;
    p1cfg_byte_t  busRdata;
    logic [7:0]   pinHighDrv;
    logic [7:0]   pinPullUp;
    logic [7:0]   pinPullDn;
    logic [7:0]   pinInBufEn;
    logic [7:0]   pinOutIllegal;
    p1cfg_idx_t   readIdx;
    logic         readDirIn;
    p1cfg_omode_t modelOut [8];
    logic [1:0]   modelIn  [8];
    p1cfg_idx_t   modelIdx;
    logic         modelDir;
    int           fail_count;
    int           n_tests;
    int           cycles;

    p1cfg_top i_p1cfg_top (
        .clk_sys       (clkSys),
        .rst_n         (rstN),
        .busAddr       (busAddr),
        .busWdata      (busWdata),
        .busWr         (busWr),
        .busRd         (busRd),
        .busRdata_r    (busRdata),
        .pinHighDrv    (pinHighDrv),
        .pinPullUp     (pinPullUp),
        .pinPullDn     (pinPullDn),
        .pinInBufEn    (pinInBufEn),
        .pinOutIllegal (pinOutIllegal),
        .readIdx_r     (readIdx),
        .readDirIn_r   (readDirIn)
    );

    ////////////////////////////////////////////////////////////////////////
    always #12.5 clkSys = ~clkSys;

    // hang guard
    always @(posedge clkSys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // pad vectors and pointer against the reference model
    task automatic checkAll();
        logic [7:0] hd;
        logic [7:0] il;
        logic [7:0] pu;
        logic [7:0] pd;
        logic [7:0] ib;
        for (int i = 0; i < 8; i++)
        begin
            hd[i] = modelOut[i] == `P1CFG_OUT_HIGH;
            il[i] = modelOut[i] != `P1CFG_OUT_NORM &&
                    modelOut[i] != `P1CFG_OUT_HIGH;
            pu[i] = modelIn[i] == 2'h2;
            pd[i] = modelIn[i] == 2'h1;
            ib[i] = modelIn[i] != 2'h3;
        end
        check(pinHighDrv, hd);
        check(pinOutIllegal, il);
        check(pinPullUp, pu);
        check(pinPullDn, pd);
        check(pinInBufEn, ib);
        check({5'h00, readIdx}, {5'h00, modelIdx});
        check({7'h00, readDirIn}, {7'h00, modelDir});
    endtask

    task automatic wr(input p1cfg_byte_t addr, input p1cfg_byte_t data);
        @(posedge clkSys);
        busAddr  <= addr;
        busWdata <= data;
        busWr    <= 1'b1;
        @(posedge clkSys);
        busWr <= 1'b0;
        if (addr == `P1CFG_ADDR && data[3])
        begin
            modelIdx = data[2:0];
            modelDir = data[4];
        end
        else if (addr == `P1CFG_ADDR && data[4])
            modelIn[data[2:0]] = data[6:5];
        else if (addr == `P1CFG_ADDR)
            modelOut[data[2:0]] = data[7:5];
        #1;
        checkAll();
    endtask

    task automatic rd(input p1cfg_byte_t addr);
        p1cfg_byte_t exp;
        exp = 8'h00;
        if (addr == `P1CFG_ADDR)
            exp = modelDir ? {1'b0, modelIn[modelIdx], 5'h00}
                           : {modelOut[modelIdx], 5'h00};
        @(posedge clkSys);
        busAddr <= addr;
        busRd   <= 1'b1;
        @(posedge clkSys);
        busRd <= 1'b0;
        #1;
        check(busRdata, exp);
        @(posedge clkSys);
        #1;
        check(busRdata, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clkSys     = 1'b0;
        rstN       = 1'b0;
        busAddr    = 8'h00;
        busWdata   = 8'h00;
        busWr      = 1'b0;
        busRd      = 1'b0;
        fail_count = 0;
        n_tests    = 0;
        cycles     = 0;
        modelIdx   = 3'h0;
        modelDir   = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            modelOut[i] = 3'h0;
            modelIn[i]  = 2'h0;
        end
        repeat (12) @(posedge clkSys);
        rstN <= 1'b0;
        @(posedge clkSys);
        rstN <= 1'b1;
        #1;
        checkAll();
        rd(`P1CFG_ADDR);
        $display("test reset state done");
        for (int i = 0; i < 8; i++)
            wr(`P1CFG_ADDR, {i[0] ? `P1CFG_OUT_HIGH : `P1CFG_OUT_NORM,
                             2'b00, 3'(i)});
        for (int i = 0; i < 8; i++)
        begin
            wr(`P1CFG_ADDR, {3'h7, 1'b0, 1'b1, 3'(i)});
            rd(`P1CFG_ADDR);
        end
        $display("test output modes done");
        // bit 7 set to show the input side ignores it
        for (int m = 0; m < 4; m++)
        begin
            wr(`P1CFG_ADDR, {1'b1, 2'(m), 1'b1, 1'b0, 3'(m + 4)});
            wr(`P1CFG_ADDR, {3'h5, 1'b1, 1'b1, 3'(m + 4)});
            rd(`P1CFG_ADDR);
        end
        $display("test input modes done");
        for (int c = 0; c < 8; c++)
        begin
            wr(`P1CFG_ADDR, {3'(c), 2'b00, 3'h2});
            wr(`P1CFG_ADDR, {3'h0, 1'b0, 1'b1, 3'h2});
            rd(`P1CFG_ADDR);
        end
        $display("test output codes done");
        wr(8'h9e, 8'h63);
        rd(8'h9e);
        rd(`P1CFG_ADDR);
        $display("test unmapped address done");
        summarize();
    end

endmodule // p1cfg_top_tb_top
